// ---- src/scw_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module scw_config_regs #(
  parameter int unsigned TICK_CYCLES = scw_pkg::US_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // command and serial front end
  input wire logic cmd_enter_in,
  input wire logic leave_cmd_mode_cmd_in,
  input wire logic addr_valid_in,
  input wire logic [6:0] rx_addr_in,
  input wire logic sclk_pin_in,
  input wire logic data_read_in,
  // alarm conditions
  input wire logic alarm_low_in,
  input wire logic alarm_high_in,
  // measurement, command and serial front end
  output scw_pkg::scw_temp_cfg_t temp_fe_out,
  output logic meas_start_out,
  output logic cmd_mode_out,
  output logic addr_match_out,
  output logic miso_shift_out,
  output logic miso_sample_edge_out,
  // pins
  output scw_pkg::scw_pin_t alarm_low_pin_out,
  output scw_pkg::scw_pin_t alarm_high_pin_out,
  output scw_pkg::scw_pin_t ready_pin_out
);
  import scw_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  scw_temp_cfg_t temp_q;
  scw_temp_cfg_t temp_act_q;
  scw_cust_cfg_t cust_q;
  scw_cust_cfg_t cust_act_q;
  scw_state_t state_q;
  scw_state_t state_d;
  scw_pin_t alarm_lo_q;
  scw_pin_t alarm_hi_q;
  scw_pin_t ready_q;
  logic [2:0] lock_q;
  logic [15:0] tick_cnt_q;
  logic [15:0] win_cnt_q;
  logic [15:0] meas_cnt_q;
  logic meas_busy_q;
  logic meas_start_q;
  logic data_ready_q;
  logic addr_match_q;
  logic sclk_prev_q;
  logic miso_shift_q;
  logic pready_q;
  logic cmd_mode_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // ---------- decode ----------
  wire tick_w = (tick_cnt_q == TICK_LAST);
  wire apb_take_w = psel_in & penable_in & ~pready_q;
  wire apb_done_w = psel_in & penable_in & pready_q;
  wire wr_w = apb_done_w & pwrite_in;
  wire sel_temp_w = (paddr_in == TEMP_ADDR);
  wire sel_cust_w = (paddr_in == CUST_ADDR);
  wire sel_status_w = (paddr_in == STATUS_ADDR);
  wire sel_active_w = (paddr_in == ACTIVE_ADDR);
  wire sel_ctrl_w = (paddr_in == CTRL_ADDR);
  wire addr_hit_w = sel_temp_w | sel_cust_w | sel_status_w | sel_active_w | sel_ctrl_w;
  wire restart_w = wr_w & sel_ctrl_w & pwdata_in[CTRL_RESTART_BIT];
  wire leave_w = (state_q == ST_CMD) & leave_cmd_mode_cmd_in;
  wire cust_load_w = restart_w | leave_w;
  wire win_end_w = tick_w & (win_cnt_q == 16'h0001);
  wire meas_go_w = (state_q == ST_NORMAL) & ~meas_busy_q & ~restart_w;
  wire meas_done_w = meas_busy_q & tick_w & (meas_cnt_q == 16'h0001);
  wire addr_ok_w = (lock_q != COMM_LOCKED) | (rx_addr_in == cust_act_q.slave_addr_field);
  wire sclk_lvl_w;
  wire sclk_rise_w = sclk_lvl_w & ~sclk_prev_q;
  wire sclk_fall_w = ~sclk_lvl_w & sclk_prev_q;
  wire [31:0] status_w = {24'h000000, 2'b00, temp_act_q.resolution, data_ready_q,
                          meas_busy_q, state_q};
  wire [31:0] rd_mux_w = sel_temp_w ? {16'h0000, temp_q} :
                         sel_cust_w ? {16'h0000, cust_q} :
                         sel_status_w ? status_w :
                         sel_active_w ? {cust_act_q, temp_act_q} :
                         sel_ctrl_w ? {29'h00000000, lock_q} : 32'h00000000;

  scw_pin_sync u_sclk_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(sclk_pin_in),
    .level_out(sclk_lvl_w)
  );

  // ---------- microsecond tick ----------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || tick_w) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ---------- apb slave, answers one cycle into the access phase ----------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_take_w;
      if (apb_take_w) begin
        pslverr_q <= ~addr_hit_w;
        prdata_q <= pwrite_in ? 32'h00000000 : rd_mux_w;
      end
    end
  end

  // stored words; reserved bits are kept as written
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      temp_q <= TEMP_RESET;
      cust_q <= CUST_RESET;
      lock_q <= LOCK_RESET;
    end else begin
      if (wr_w && sel_temp_w) begin
        temp_q <= pwdata_in[15:0];
      end
      if (wr_w && sel_cust_w) begin
        cust_q <= pwdata_in[15:0];
      end
      if (wr_w && sel_ctrl_w) begin
        lock_q <= pwdata_in[CTRL_LOCK_LSB +: 3];
      end
    end
  end

  // ---------- startup window and command mode ----------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_WINDOW: begin
        if (cmd_enter_in) begin
          state_d = ST_CMD;
        end else if (win_end_w) begin
          state_d = ST_NORMAL;
        end
      end
      ST_CMD: begin
        if (leave_cmd_mode_cmd_in) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        state_d = ST_NORMAL;
      end
      default: begin
        state_d = ST_WINDOW;
      end
    endcase
    if (restart_w) begin
      state_d = ST_WINDOW;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_WINDOW;
      cmd_mode_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_mode_q <= (state_d == ST_CMD);
    end
  end

  // reset window uses the reset customer word, whose fast bit is clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      win_cnt_q <= T_WIN_SLOW_US;
    end else if (restart_w) begin
      win_cnt_q <= scw_window_us(cust_q.fast_startup);
    end else if (state_q == ST_WINDOW && tick_w && win_cnt_q != 16'h0000) begin
      win_cnt_q <= win_cnt_q - 16'h0001;
    end
  end

  // working customer copy changes only on a load event
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cust_act_q <= CUST_RESET;
    end else if (cust_load_w) begin
      cust_act_q <= cust_q;
    end
  end

  // ---------- measurement sequencer ----------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      temp_act_q <= TEMP_RESET;
      meas_busy_q <= 1'b0;
      meas_cnt_q <= 16'h0000;
      meas_start_q <= 1'b0;
    end else begin
      meas_start_q <= meas_go_w;
      if (meas_go_w) begin
        temp_act_q <= temp_q;
        meas_busy_q <= 1'b1;
        meas_cnt_q <= scw_period_us(temp_q.resolution);
      end else begin
        if (restart_w || meas_done_w) begin
          meas_busy_q <= 1'b0;
        end
        if (meas_busy_q && tick_w && meas_cnt_q != 16'h0000) begin
          meas_cnt_q <= meas_cnt_q - 16'h0001;
        end
      end
    end
  end

  // new result beats a read in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      data_ready_q <= 1'b0;
    end else if (meas_done_w) begin
      data_ready_q <= 1'b1;
    end else if (data_read_in) begin
      data_ready_q <= 1'b0;
    end
  end

  // ---------- serial address and read-data edge ----------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      addr_match_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      miso_shift_q <= 1'b0;
    end else begin
      addr_match_q <= addr_valid_in & addr_ok_w;
      sclk_prev_q <= sclk_lvl_w;
      // shift on the edge opposite to the one the master samples on
      miso_shift_q <= cust_act_q.spi_phase ? sclk_rise_w : sclk_fall_w;
    end
  end

  // ---------- pin drivers ----------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      alarm_lo_q <= scw_drive(1'b0, 1'b0, 1'b0);
      alarm_hi_q <= scw_drive(1'b0, 1'b0, 1'b0);
      ready_q <= scw_drive(1'b0, 1'b0, 1'b0);
    end else begin
      alarm_lo_q <= scw_drive(alarm_low_in, cust_act_q.lo_pol, cust_act_q.lo_od);
      alarm_hi_q <= scw_drive(alarm_high_in, cust_act_q.hi_pol, cust_act_q.hi_od);
      ready_q <= scw_drive(data_ready_q, 1'b0, cust_act_q.ready_od);
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign temp_fe_out = temp_act_q;
  assign meas_start_out = meas_start_q;
  assign cmd_mode_out = cmd_mode_q;
  assign addr_match_out = addr_match_q;
  assign miso_shift_out = miso_shift_q;
  assign miso_sample_edge_out = cust_act_q.spi_phase;
  assign alarm_low_pin_out = alarm_lo_q;
  assign alarm_high_pin_out = alarm_hi_q;
  assign ready_pin_out = ready_q;

  // ---------- checks ----------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_reload_at_start;
    meas_start_out |-> temp_fe_out == $past(temp_q);
  endproperty
  a_reload_at_start: assert property (p_reload_at_start)
    else $error("temperature word not reloaded at measurement start");

  property p_period;
    meas_go_w ##1 meas_busy_q |-> meas_cnt_q == scw_period_us(temp_fe_out.resolution);
  endproperty
  a_period: assert property (p_period)
    else $error("sample period does not match resolution code");

  property p_worst_case;
    meas_busy_q |-> meas_cnt_q <= scw_worst_us(temp_fe_out.resolution);
  endproperty
  a_worst_case: assert property (p_worst_case)
    else $error("measurement exceeds worst-case duration");

  property p_defaults;
    $rose(rst_n_in) |-> temp_fe_out.conv_ref_cap_sel == 3'h2
      && temp_fe_out.conv_offset_cap_sel == 3'h2 && temp_fe_out.temp_trim == 3'h6;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("temperature front-end defaults wrong after reset");

  property p_cust_load;
    leave_w |=> cust_act_q == $past(cust_q) && state_q == ST_NORMAL;
  endproperty
  a_cust_load: assert property (p_cust_load)
    else $error("customer word not loaded on leaving command mode");

  property p_cust_hold;
    !cust_load_w |=> cust_act_q == $past(cust_act_q);
  endproperty
  a_cust_hold: assert property (p_cust_hold)
    else $error("customer options changed without a load event");

  property p_alarm_low_od;
    alarm_low_in && cust_act_q.lo_od && !cust_act_q.lo_pol
      |=> !alarm_low_pin_out.oe ##1 (alarm_low_pin_out.oe == $past(!alarm_low_in, 1)
      || $past(cust_load_w, 2));
  endproperty
  a_alarm_low_od: assert property (p_alarm_low_od)
    else $error("open-drain low alarm driven while asserted high");

  property p_alarm_high_pp;
    alarm_high_in && !cust_act_q.hi_od && cust_act_q.hi_pol
      |=> alarm_high_pin_out.oe && !alarm_high_pin_out.o;
  endproperty
  a_alarm_high_pp: assert property (p_alarm_high_pp)
    else $error("push-pull active-low high alarm not driven low");

  property p_miso_edge;
    sclk_rise_w && !cust_act_q.spi_phase |=> !miso_shift_out;
  endproperty
  a_miso_edge: assert property (p_miso_edge)
    else $error("read data shifted on the master sampling edge");

  property p_window_len;
    restart_w |=> state_q == ST_WINDOW
      && win_cnt_q == (cust_act_q.fast_startup ? T_WIN_FAST_US : T_WIN_SLOW_US);
  endproperty
  a_window_len: assert property (p_window_len)
    else $error("command window length does not follow fast startup bit");

  property p_addr_lock;
    addr_valid_in && lock_q == COMM_LOCKED
      && rx_addr_in != cust_act_q.slave_addr_field |=> !addr_match_out;
  endproperty
  a_addr_lock: assert property (p_addr_lock)
    else $error("locked device answered a foreign address");

  c_meas_done: cover property (meas_done_w ##1 data_ready_q);
  c_cmd_leave: cover property (state_q == ST_CMD ##1 state_q == ST_NORMAL);
  c_addr_match: cover property (addr_valid_in && lock_q == COMM_LOCKED ##1 addr_match_out);
  c_restart_fast: cover property (restart_w && cust_q.fast_startup);
endmodule
`default_nettype wire

// ---- src/scw_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module scw_pin_sync (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // asynchronous pin
  input wire logic pin_in,
  // filtered level
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      level_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ---- src/scw_pkg.sv ----
`default_nettype none
package scw_pkg;

  // clock and derived timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned US_CYCLES = CLK_MHZ;
  localparam logic [15:0] T_RES8_US = 16'h02BC;
  localparam logic [15:0] T_RES10_US = 16'h0640;
  localparam logic [15:0] T_RES12_US = 16'h1388;
  localparam logic [15:0] T_RES14_US = 16'h4844;
  localparam logic [15:0] T_WIN_SLOW_US = 16'h2710;
  localparam logic [15:0] T_WIN_FAST_US = 16'h0BB8;
  localparam int unsigned WC_NUM = 11;
  localparam int unsigned WC_DEN = 10;

  // register map, printed offsets kept as word indices
  localparam logic [7:0] TEMP_IDX = 8'h11;
  localparam logic [7:0] CUST_IDX = 8'h1C;
  localparam logic [7:0] TEMP_ADDR = {TEMP_IDX[5:0], 2'b00};
  localparam logic [7:0] CUST_ADDR = {CUST_IDX[5:0], 2'b00};
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] ACTIVE_ADDR = 8'h04;
  localparam logic [7:0] CTRL_ADDR = 8'h08;

  // reset values and control fields
  localparam logic [15:0] TEMP_RESET = 16'h8D92;
  localparam logic [15:0] CUST_RESET = 16'h0028;
  localparam logic [2:0] COMM_LOCKED = 3'h3;
  localparam logic [2:0] LOCK_RESET = 3'h3;
  localparam int unsigned CTRL_LOCK_LSB = 0;
  localparam int unsigned CTRL_RESTART_BIT = 3;

  typedef enum logic [1:0] {
    ST_WINDOW = 2'b00,
    ST_CMD = 2'b01,
    ST_NORMAL = 2'b10
  } scw_state_t;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] resolution;
    logic rsvd_9;
    logic [2:0] temp_trim;
    logic [2:0] conv_offset_cap_sel;
    logic [2:0] conv_ref_cap_sel;
  } scw_temp_cfg_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic fast_startup;
    logic ready_od;
    logic spi_phase;
    logic hi_od;
    logic hi_pol;
    logic lo_od;
    logic lo_pol;
    logic [6:0] slave_addr_field;
  } scw_cust_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } scw_pin_t;

  function automatic logic [15:0] scw_period_us(input logic [1:0] res);
    logic [15:0] p;
    p = T_RES14_US;
    unique case (res)
      2'b00: p = T_RES8_US;
      2'b01: p = T_RES10_US;
      2'b10: p = T_RES12_US;
      2'b11: p = T_RES14_US;
    endcase
    return p;
  endfunction

  function automatic logic [15:0] scw_worst_us(input logic [1:0] res);
    logic [31:0] t;
    t = 32'(scw_period_us(res)) * WC_NUM / WC_DEN;
    return t[15:0];
  endfunction

  function automatic logic [15:0] scw_window_us(input logic fast);
    return fast ? T_WIN_FAST_US : T_WIN_SLOW_US;
  endfunction

  // open drain can only pull low, so the line is released for high
  function automatic scw_pin_t scw_drive(input logic active, input logic pol,
                                         input logic od);
    scw_pin_t p;
    logic lvl;
    lvl = active ^ pol;
    p.o = od ? 1'b0 : lvl;
    p.oe = od ? ~lvl : 1'b1;
    return p;
  endfunction

endpackage
`default_nettype wire

// ---- verif/scw_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module scw_host_model (
  // clock
  input wire logic core_clk_in,
  // device reply
  input wire logic addr_match_in,
  // command and serial lines
  output logic cmd_enter_out,
  output logic leave_cmd_out,
  output logic addr_valid_out,
  output logic [6:0] rx_addr_out,
  output logic sclk_out,
  output logic data_read_out
);
  initial begin
    cmd_enter_out = 1'b0;
    leave_cmd_out = 1'b0;
    addr_valid_out = 1'b0;
    rx_addr_out = 7'h55;
    sclk_out = 1'b0;
    data_read_out = 1'b0;
  end

  // k: 0 enter command mode, 1 start normal operation, 2 result read
  task automatic pulse(input int k);
    if (k == 0) cmd_enter_out <= 1'b1;
    else if (k == 1) leave_cmd_out <= 1'b1;
    else data_read_out <= 1'b1;
    @(posedge core_clk_in);
    cmd_enter_out <= 1'b0;
    leave_cmd_out <= 1'b0;
    data_read_out <= 1'b0;
  endtask

  task automatic send_addr(input logic [6:0] a, output logic m);
    addr_valid_out <= 1'b1;
    rx_addr_out <= a;
    @(posedge core_clk_in);
    addr_valid_out <= 1'b0;
    // a released bus does not keep showing the last address
    rx_addr_out <= ~a;
    @(posedge core_clk_in);
    m = addr_match_in;
  endtask

  // serial clock rests low between frames
  task automatic frame(input int n);
    repeat (n) begin
      sclk_out <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      sclk_out <= 1'b0;
      repeat (6) @(posedge core_clk_in);
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/sensor_config_words_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module sensor_config_words_bench;
  import scw_pkg::*;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] data;
    logic err;
  } scw_note_t;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, cmd_enter_in, leave_in, addr_valid_in;
  logic sclk_pin_in, data_read_in, m;
  logic [6:0] rx_addr_in;
  logic alarm_low_in = 1'b0;
  logic alarm_high_in = 1'b0;
  scw_temp_cfg_t temp_fe_out;
  logic meas_start_out, cmd_mode_out, addr_match_out, miso_shift_out, miso_sample_edge_out;
  scw_pin_t alarm_low_pin_out, alarm_high_pin_out, ready_pin_out;
  int errors = 0;
  int num_checks = 0;
  int shifts = 0;
  int n;
  integer seed = 32'h01ba;
  logic [15:0] tw;
  scw_note_t nt;
  scw_note_t notes[$];

  scw_config_regs #(.TICK_CYCLES(2)) DUT (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cmd_enter_in(cmd_enter_in), .leave_cmd_mode_cmd_in(leave_in),
    .addr_valid_in(addr_valid_in), .rx_addr_in(rx_addr_in),
    .sclk_pin_in(sclk_pin_in), .data_read_in(data_read_in),
    .alarm_low_in(alarm_low_in), .alarm_high_in(alarm_high_in),
    .temp_fe_out(temp_fe_out), .meas_start_out(meas_start_out),
    .cmd_mode_out(cmd_mode_out), .addr_match_out(addr_match_out),
    .miso_shift_out(miso_shift_out), .miso_sample_edge_out(miso_sample_edge_out),
    .alarm_low_pin_out(alarm_low_pin_out), .alarm_high_pin_out(alarm_high_pin_out),
    .ready_pin_out(ready_pin_out)
  );

  scw_host_model host (
    .core_clk_in(core_clk_in), .addr_match_in(addr_match_out),
    .cmd_enter_out(cmd_enter_in), .leave_cmd_out(leave_in),
    .addr_valid_out(addr_valid_in), .rx_addr_out(rx_addr_in),
    .sclk_out(sclk_pin_in), .data_read_out(data_read_in)
  );

  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    if (miso_shift_out === 1'b1) shifts <= shifts + 1;
  end

  // oldest note is the answer expected for this completed transfer
  always @(posedge core_clk_in) begin
    if (pready_out === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      `CHK("prdata", nt.data & nt.mask, prdata_out & nt.mask)
      `CHK("pslverr", nt.err, pslverr_out)
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] mk, input logic e);
    int k;
    notes.push_back('{wr ? 32'h0 : mk, d, e});
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wr ? d : ~d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    `CHK("pready", 1'b1, pready_out)
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  task automatic wait_meas(output int c);
    c = 0;
    do begin
      @(posedge core_clk_in);
      c++;
    end while (meas_start_out !== 1'b1 && c < 45000);
    if (c >= 45000) errors++;
  endtask

  initial begin
    #300000;
    errors++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    `CHK("temp_fe", 16'h8D92, temp_fe_out)
    `CHK("low_pin", 2'h1, alarm_low_pin_out)
    apb(1'b0, TEMP_ADDR, 32'h8D92, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, CUST_ADDR, 32'h0028, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, ACTIVE_ADDR, 32'h00288D92, 32'hFFFFFFFF, 1'b0);
    apb(1'b1, 8'h0C, $random(seed), 32'h0, 1'b1);
    apb(1'b0, 8'hF0, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test reset values done");
    host.send_addr(7'h28, m);
    `CHK("match", 1'b1, m)
    host.send_addr(7'h13, m);
    `CHK("match", 1'b0, m)
    $display("test address lock done");
    host.pulse(0);
    repeat (2) @(posedge core_clk_in);
    `CHK("cmd_mode", 1'b1, cmd_mode_out)
    apb(1'b1, CUST_ADDR, 32'h0CB5, 32'h0, 1'b0);
    apb(1'b0, CUST_ADDR, 32'h0CB5, 32'hFFFFFFFF, 1'b0);
    apb(1'b0, ACTIVE_ADDR, 32'h00288D92, 32'hFFFFFFFF, 1'b0);
    host.send_addr(7'h35, m);
    `CHK("match", 1'b0, m)
    `CHK("edge", 1'b0, miso_sample_edge_out)
    n = shifts;
    host.frame(2);
    repeat (8) @(posedge core_clk_in);
    `CHK("shifts", 2, shifts - n)
    host.pulse(1);
    repeat (2) @(posedge core_clk_in);
    `CHK("cmd_mode", 1'b0, cmd_mode_out)
    `CHK("edge", 1'b1, miso_sample_edge_out)
    apb(1'b0, ACTIVE_ADDR, 32'h0CB58D92, 32'hFFFFFFFF, 1'b0);
    host.send_addr(7'h35, m);
    `CHK("match", 1'b1, m)
    for (int i = 0; i < 4; i++) begin
      alarm_low_in <= i[0];
      alarm_high_in <= i[1];
      repeat (4) @(posedge core_clk_in);
      `CHK("low_pin", {~i[0], 1'b1}, alarm_low_pin_out)
      `CHK("high_pin", {1'b0, ~i[1]}, alarm_high_pin_out)
    end
    n = shifts;
    host.frame(4);
    repeat (8) @(posedge core_clk_in);
    `CHK("shifts", 4, shifts - n)
    host.pulse(2);
    $display("test customer load done");
    tw = {4'h8, 2'b00, 1'b0, 9'($random(seed))};
    apb(1'b1, TEMP_ADDR, {16'h0, tw}, 32'h0, 1'b0);
    apb(1'b1, CUST_ADDR, 32'h2B35, 32'h0, 1'b0);
    // lock field kept at 011 while the restart bit fires
    apb(1'b1, CTRL_ADDR, 32'h000B, 32'h0, 1'b0);
    wait_meas(n);
    `CHK("window", 1'b1, n >= 5990 && n <= 6600)
    `CHK("temp_fe", tw, temp_fe_out)
    apb(1'b0, ACTIVE_ADDR, {16'h2B35, tw}, 32'hFFFFFFFF, 1'b0);
    // both alarms still raised: low now open drain, high now active low
    `CHK("low_pin", 2'h0, alarm_low_pin_out)
    `CHK("high_pin", 2'h1, alarm_high_pin_out)
    apb(1'b0, STATUS_ADDR, 32'h2, 32'h33, 1'b0);
    $display("test short window done");
    for (int r = 1; r < 4; r++) begin
      tw = {4'h8, r[1:0], 1'b0, 9'($random(seed))};
      apb(1'b1, TEMP_ADDR, {16'h0, tw}, 32'h0, 1'b0);
      wait_meas(n);
      `CHK("temp_fe", tw, temp_fe_out)
      `CHK("ready_pin", 2'h3, ready_pin_out)
      host.pulse(2);
      repeat (2) @(posedge core_clk_in);
      `CHK("ready_pin", 2'h1, ready_pin_out)
      apb(1'b0, STATUS_ADDR, {26'h0, r[1:0], 4'h2}, 32'h33, 1'b0);
    end
    $display("test resolutions done");
    conclude();
  end
endmodule
`default_nettype wire
